// ==== pmc_pkg.sv ====
package pmc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_CORE_PWR   = 4'h0;  // core_power_ctrl_reg
  localparam logic [3:0] OFS_WAKE_CFG   = 4'h1;  // wake_config_reg
  localparam logic [3:0] OFS_SUPV_CTRL  = 4'h2;  // supervision / lost clock enables
  localparam logic [3:0] OFS_STATUS     = 4'h3;  // current mode status

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CP_IDLE      = 0;
  localparam int CP_STOP      = 1;
  localparam int WK_CPT0      = 0;
  localparam int WK_PMAT      = 1;
  localparam int WK_RTCA      = 2;
  localparam int WK_RTCF      = 3;
  localparam int WK_RSTP      = 4;
  localparam int WK_CLEAR     = 5;
  localparam int WK_SUSPEND   = 6;
  localparam int WK_SLEEP     = 7;
  localparam int SV_WDOG_EN   = 0;
  localparam int SV_LCD_EN    = 1;
  localparam int SV_TWO_CELL  = 2;

  localparam int          NUM_WAKE     = 4;
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int FLAG_HOLD_CLKS = 2;
  localparam int LCD_TIMEOUT_US = 100;
  localparam int LCD_TIMEOUT_CYC = LCD_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    PMC_NORMAL  = 3'b000,
    PMC_IDLE    = 3'b001,
    PMC_STOP    = 3'b010,
    PMC_SUSPEND = 3'b011,
    PMC_SLEEP   = 3'b100
  } pmc_mode_e;

endpackage : pmc_pkg

// ==== pmc_wake_sync.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Two-flop synchroniser for asynchronous wake levels
// ---------------------------------------------------------------
module pmc_wake_sync #(
  parameter int W = 5
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_level = sync_q;
endmodule : pmc_wake_sync

// ==== pmc_ctrl.sv ====
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
module pmc_ctrl #(
  parameter int LCD_CYC = pmc_pkg::LCD_TIMEOUT_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_instr_done,
  input  wire logic        i_irq_pending,
  input  wire logic        i_reset_event,
  input  wire logic        i_wdog_expire,
  input  wire logic        i_rtc_fail,
  input  wire logic        i_rtc_alarm,
  input  wire logic        i_port_match,
  input  wire logic        i_cmp0,
  input  wire logic        i_rst_pin_b,
  output logic [7:0]       o_rdata,
  output logic             o_cpu_halt,
  output logic             o_clk_gate,
  output logic             o_prec_osc_en,
  output logic             o_int_osc_en,
  output logic             o_sys_reset,
  output logic [15:0]      o_reset_vector,
  output logic [2:0]       o_mode
);

  // ---------------------------------------------------------------
  // Synchronised wake inputs
  // ---------------------------------------------------------------
  logic [4:0] wk_lvl;
  logic [4:0] wk_lvl_q;
  logic [4:0] wk_rise;

  pmc_wake_sync #(.W(5)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_async   ({~i_rst_pin_b, i_rtc_fail, i_rtc_alarm, i_port_match, i_cmp0}),
    .o_level   (wk_lvl)
  );

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      wk_lvl_q <= '0;
    else
      wk_lvl_q <= wk_lvl;
  end

  assign wk_rise = wk_lvl & ~wk_lvl_q;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  pmc_pkg::pmc_mode_e mode_q;
  pmc_pkg::pmc_mode_e mode_d;
  logic [1:0]  core_sel_q;
  logic [3:0]  wake_en_q;
  logic [4:0]  flags_q;
  logic [2:0]  supv_q;
  logic [1:0]  hold_q;
  logic        pend_idle_q;
  logic        pend_stop_q;
  logic [31:0] lcd_cnt_q;
  logic        lcd_fire;
  logic        wr_core;
  logic        wr_wake;
  logic        clr_all;
  logic        req_lp;
  logic        flags_blocked;
  logic [3:0]  wake_hit;
  logic        any_wake;
  logic        rst_any;

  assign wr_core = i_wr && (i_addr == pmc_pkg::OFS_CORE_PWR);
  assign wr_wake = i_wr && (i_addr == pmc_pkg::OFS_WAKE_CFG);
  assign clr_all = wr_wake && i_wdata[pmc_pkg::WK_CLEAR];
  assign req_lp  = wr_wake && (i_wdata[pmc_pkg::WK_SLEEP] || i_wdata[pmc_pkg::WK_SUSPEND]);

  // Entry refused while any newly enabled source still has its flag set
  assign flags_blocked = |(flags_q[3:0] & i_wdata[3:0]);

  // Comparator wake masked in sleep unless two-cell supply
  always_comb
  begin
    wake_hit = wake_en_q & wk_lvl[3:0];
    if (mode_q == pmc_pkg::PMC_SLEEP && !supv_q[pmc_pkg::SV_TWO_CELL])
      wake_hit[pmc_pkg::WK_CPT0] = 1'b0;
  end

  assign any_wake = (|wake_hit) || wk_lvl[pmc_pkg::WK_RSTP];

  // Lost clock detector and watchdog both force a full reset
  assign rst_any = i_reset_event || lcd_fire
                   || (i_wdog_expire && supv_q[pmc_pkg::SV_WDOG_EN]);

  // ---------------------------------------------------------------
  // Software-visible control
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      supv_q <= 3'b000;
    else if (i_wr && (i_addr == pmc_pkg::OFS_SUPV_CTRL))
      supv_q <= i_wdata[2:0];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b || rst_any)
      wake_en_q <= '0;
    else if (req_lp)
      wake_en_q <= i_wdata[3:0];
    else if (wr_wake)
      wake_en_q <= i_wdata[3:0];
  end

  // Flags: set wins over clear, updates in every mode
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      flags_q <= '0;
    else
      flags_q <= (clr_all ? 5'b0_0000 : flags_q)
                 | {wk_rise[4], wk_lvl[3:0] & ~wk_lvl_q[3:0]};
  end

  // Flag hold-off after a wake from suspend
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      hold_q <= '0;
    else if ((mode_q == pmc_pkg::PMC_SUSPEND) && any_wake)
      hold_q <= 2'(pmc_pkg::FLAG_HOLD_CLKS);
    else if (hold_q != 2'b00)
      hold_q <= hold_q - 2'b01;
  end

  // ---------------------------------------------------------------
  // Mode requests wait for the issuing instruction
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b || rst_any)
    begin
      pend_idle_q <= 1'b0;
      pend_stop_q <= 1'b0;
    end
    else if (wr_core)
    begin
      pend_idle_q <= i_wdata[pmc_pkg::CP_IDLE];
      pend_stop_q <= i_wdata[pmc_pkg::CP_STOP];
    end
    else if (i_instr_done)
    begin
      pend_idle_q <= 1'b0;
      pend_stop_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b || rst_any)
      core_sel_q <= 2'b00;
    else if (mode_q == pmc_pkg::PMC_IDLE && i_irq_pending)
      core_sel_q[pmc_pkg::CP_IDLE] <= 1'b0;
    else if (wr_core)
      core_sel_q <= i_wdata[1:0];
  end

  // ---------------------------------------------------------------
  // Mode state machine
  // ---------------------------------------------------------------
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      pmc_pkg::PMC_NORMAL:
      begin
        if (req_lp && !flags_blocked)
          mode_d = i_wdata[pmc_pkg::WK_SLEEP] ? pmc_pkg::PMC_SLEEP
                                              : pmc_pkg::PMC_SUSPEND;
        else if (i_instr_done && pend_stop_q)
          mode_d = pmc_pkg::PMC_STOP;
        else if (i_instr_done && pend_idle_q)
          mode_d = pmc_pkg::PMC_IDLE;
      end
      pmc_pkg::PMC_IDLE:
        if (i_irq_pending)
          mode_d = pmc_pkg::PMC_NORMAL;
      pmc_pkg::PMC_STOP:
        mode_d = pmc_pkg::PMC_STOP;
      pmc_pkg::PMC_SUSPEND,
      pmc_pkg::PMC_SLEEP:
        if (any_wake)
          mode_d = pmc_pkg::PMC_NORMAL;
      default:
        mode_d = pmc_pkg::PMC_NORMAL;
    endcase
    if (rst_any)
      mode_d = pmc_pkg::PMC_NORMAL;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      mode_q <= pmc_pkg::PMC_NORMAL;
    else
      mode_q <= mode_d;
  end

  // Lost clock detector counts only while stopped
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b || mode_q != pmc_pkg::PMC_STOP || !supv_q[pmc_pkg::SV_LCD_EN])
      lcd_cnt_q <= '0;
    else if (lcd_cnt_q != 32'(LCD_CYC))
      lcd_cnt_q <= lcd_cnt_q + 32'd1;
  end

  assign lcd_fire = (mode_q == pmc_pkg::PMC_STOP) && supv_q[pmc_pkg::SV_LCD_EN]
                    && (lcd_cnt_q == 32'(LCD_CYC - 1));

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      o_cpu_halt    <= 1'b0;
      o_clk_gate    <= 1'b0;
      o_prec_osc_en <= 1'b1;
      o_int_osc_en  <= 1'b1;
      o_mode        <= 3'b000;
    end
    else
    begin
      // Idle halts only the core; peripherals and state stay live
      o_cpu_halt    <= mode_d != pmc_pkg::PMC_NORMAL;
      o_prec_osc_en <= mode_d == pmc_pkg::PMC_NORMAL
                       || mode_d == pmc_pkg::PMC_IDLE;
      o_clk_gate    <= mode_d == pmc_pkg::PMC_SUSPEND
                       || mode_d == pmc_pkg::PMC_SLEEP;
      o_int_osc_en  <= !(mode_d == pmc_pkg::PMC_SUSPEND
                       || mode_d == pmc_pkg::PMC_SLEEP);
      o_mode        <= mode_d;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      o_sys_reset    <= 1'b0;
      o_reset_vector <= pmc_pkg::RESET_VECTOR;
    end
    else
    begin
      o_sys_reset    <= rst_any;
      o_reset_vector <= pmc_pkg::RESET_VECTOR;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      o_rdata <= pmc_pkg::RESET_BYTE;
    else if (!i_rd)
      o_rdata <= pmc_pkg::RESET_BYTE;
    else
      case (i_addr)
        pmc_pkg::OFS_CORE_PWR:  o_rdata <= {6'b00_0000, core_sel_q};
        pmc_pkg::OFS_WAKE_CFG:  o_rdata <= (hold_q != 2'b00) ? 8'h00
                                           : {3'b000, flags_q};
        pmc_pkg::OFS_SUPV_CTRL: o_rdata <= {5'b0_0000, supv_q};
        pmc_pkg::OFS_STATUS:    o_rdata <= {5'b0_0000, mode_q};
        default:                o_rdata <= pmc_pkg::RESET_BYTE;
      endcase
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_stop_sticky;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (mode_q == pmc_pkg::PMC_STOP && !rst_any) |=> (mode_q == pmc_pkg::PMC_STOP);
  endproperty
  a_stop_sticky: assert property (p_stop_sticky) else $error("stop left without reset");

  property p_idle_exit;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (mode_q == pmc_pkg::PMC_IDLE && i_irq_pending) |=> (mode_q == pmc_pkg::PMC_NORMAL && !o_cpu_halt);
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle did not end on irq");

  property p_susp_gate;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (mode_q == pmc_pkg::PMC_SUSPEND) |-> (o_clk_gate && !o_int_osc_en);
  endproperty
  a_susp_gate: assert property (p_susp_gate) else $error("suspend clock not gated");

  property p_flag_zero;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (mode_q == pmc_pkg::PMC_SUSPEND && any_wake ##1 i_rd && i_addr == pmc_pkg::OFS_WAKE_CFG)
      |=> (o_rdata == 8'h00);
  endproperty
  a_flag_zero: assert property (p_flag_zero) else $error("flags nonzero after wake");

  property p_rst_vec;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      rst_any |=> (o_sys_reset && o_reset_vector == pmc_pkg::RESET_VECTOR && o_mode == 3'b000);
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset sequence missing");

  property p_lcd;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      lcd_fire |=> (mode_q == pmc_pkg::PMC_NORMAL);
  endproperty
  a_lcd: assert property (p_lcd) else $error("lost clock did not reset stop");

  property p_pin_wake;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (mode_q == pmc_pkg::PMC_SLEEP && wk_lvl[pmc_pkg::WK_RSTP] && !rst_any)
      |=> (mode_q == pmc_pkg::PMC_NORMAL && !o_sys_reset);
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin glitch did not wake");

  property p_prio;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (mode_q == pmc_pkg::PMC_NORMAL && req_lp && !flags_blocked && !rst_any
       && i_wdata[pmc_pkg::WK_SLEEP]) |=> (mode_q == pmc_pkg::PMC_SLEEP);
  endproperty
  a_prio: assert property (p_prio) else $error("sleep priority broken");

endmodule : pmc_ctrl

// ==== pmc_core_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Core and wake-source stand-in
// ---------------------------------------------------------------
module pmc_core_model (
  input  wire logic  i_ref_clk,
  output logic       o_instr_done,
  output logic       o_irq_pending,
  output logic [3:0] o_wake,
  output logic       o_rst_pin_b
);
  initial
  begin
    o_instr_done  = 1'b0;
    o_irq_pending = 1'b0;
    o_wake        = 4'h0;
    o_rst_pin_b   = 1'b1;
  end

  // Mode request retires one cycle later
  task automatic step();
    @(posedge i_ref_clk);
    o_instr_done <= 1'b1;
    @(posedge i_ref_clk);
    o_instr_done <= 1'b0;
  endtask : step

  task automatic irq(input logic lvl);
    @(posedge i_ref_clk);
    o_irq_pending <= lvl;
  endtask : irq

  // Off the edge on purpose: these sources are asynchronous
  task automatic wake(input int idx, input logic lvl);
    @(posedge i_ref_clk);
    #1.3 o_wake[idx] = lvl;
  endtask : wake

  // Two-cycle dip: seen by the sync, far too short to reset
  task automatic pin_glitch();
    @(posedge i_ref_clk);
    #1.1 o_rst_pin_b = 1'b0;
    #8 o_rst_pin_b = 1'b1;
  endtask : pin_glitch
endmodule : pmc_core_model

// ==== power_mode_controller_tb.sv ====
`timescale 1ns/1ps
module power_mode_controller_tb;
  localparam int LCD = 20;
  logic        ref_clk = 1'b0;
  logic        rst_b;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic        reset_event;
  logic        wdog_expire;
  logic        instr_done, irq_pending, rst_pin_b;
  logic [3:0]  wake;
  logic [7:0]  rdata;
  logic        cpu_halt, clk_gate, prec_osc_en, int_osc_en, sys_reset;
  logic [15:0] reset_vector;
  logic [2:0]  mode;
  logic [15:0] n_rst = 16'h0000;
  logic [15:0] exp_rst = 16'h0000;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #2 ref_clk = ~ref_clk;

  pmc_ctrl #(.LCD_CYC(LCD)) u_pmc_ctrl (
    .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .i_instr_done(instr_done), .i_irq_pending(irq_pending),
    .i_reset_event(reset_event), .i_wdog_expire(wdog_expire), .i_rtc_fail(wake[3]),
    .i_rtc_alarm(wake[2]), .i_port_match(wake[1]), .i_cmp0(wake[0]),
    .i_rst_pin_b(rst_pin_b), .o_rdata(rdata), .o_cpu_halt(cpu_halt), .o_clk_gate(clk_gate),
    .o_prec_osc_en(prec_osc_en), .o_int_osc_en(int_osc_en), .o_sys_reset(sys_reset),
    .o_reset_vector(reset_vector), .o_mode(mode));

  pmc_core_model u_pmc_core_model (
    .i_ref_clk(ref_clk), .o_instr_done(instr_done), .o_irq_pending(irq_pending),
    .o_wake(wake), .o_rst_pin_b(rst_pin_b));

  // Counted mid-cycle so a check at the next rising edge already sees it
  always @(negedge ref_clk)
  begin
    if (sys_reset === 1'b1)
      n_rst <= n_rst + 16'h0001;
  end

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_reg(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(posedge ref_clk);
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask : chk_reg

  // Control nibble: halt, gate, precision osc, internal osc
  task automatic st(input logic [2:0] m, input logic [3:0] c);
    chk("state", {9'h000, m, c}, {9'h000, mode, cpu_halt, clk_gate, prec_osc_en, int_osc_en});
    chk("resets", exp_rst, n_rst);
  endtask : st

  task automatic wait_mode(input logic [2:0] m);
    for (int k = 0; k < 60 && mode !== m; k++)
      @(posedge ref_clk);
  endtask : wait_mode

  // Back-to-back reads; with hold the two reads after wake must give zero
  task automatic wake_watch(input logic hold);
    @(posedge ref_clk);
    addr <= pmc_pkg::OFS_WAKE_CFG;
    rd   <= 1'b1;
    wait_mode(pmc_pkg::PMC_NORMAL);
    chk("early flags", 16'h0000, {8'h00, rdata});
    if (hold)
    begin
      repeat (2)
      begin
        @(posedge ref_clk);
        chk("held flags", 16'h0000, {8'h00, rdata});
      end
    end
    rd <= 1'b0;
  endtask : wake_watch

  task automatic kick(input logic wd);
    @(posedge ref_clk);
    wdog_expire <= wd;
    reset_event <= ~wd;
    @(posedge ref_clk);
    wdog_expire <= 1'b0;
    reset_event <= 1'b0;
  endtask : kick

  task automatic enter(input logic [7:0] core);
    wr_reg(pmc_pkg::OFS_CORE_PWR, core);
    u_pmc_core_model.step();
    wait_mode(core[1] ? pmc_pkg::PMC_STOP : pmc_pkg::PMC_IDLE);
  endtask : enter

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    rst_b       <= 1'b0;
    addr        <= 4'h0;
    wdata       <= 8'h00;
    wr          <= 1'b0;
    rd          <= 1'b0;
    reset_event <= 1'b0;
    wdog_expire <= 1'b0;
    tick(2);
    rst_b <= 1'b1;
    tick(3);
    st(pmc_pkg::PMC_NORMAL, 4'h3);
    chk("vector", 16'h0000, reset_vector);
    chk_reg("status", pmc_pkg::OFS_STATUS, 8'h00);
    $display("test reset done");
    // No divider, bias or flash-timing port: core side assumed ready
    wr_reg(pmc_pkg::OFS_SUPV_CTRL, 8'h04);
    wr_reg(pmc_pkg::OFS_CORE_PWR, 8'h01);
    tick(3);
    st(pmc_pkg::PMC_NORMAL, 4'h3);
    u_pmc_core_model.step();
    wait_mode(pmc_pkg::PMC_IDLE);
    st(pmc_pkg::PMC_IDLE, 4'hB);
    u_pmc_core_model.irq(1'b1);
    wait_mode(pmc_pkg::PMC_NORMAL);
    st(pmc_pkg::PMC_NORMAL, 4'h3);
    u_pmc_core_model.irq(1'b0);
    chk_reg("idle bit", pmc_pkg::OFS_CORE_PWR, 8'h00);
    chk_reg("kept reg", pmc_pkg::OFS_SUPV_CTRL, 8'h04);
    $display("test idle done");
    wr_reg(pmc_pkg::OFS_SUPV_CTRL, 8'h05);
    enter(8'h01);
    kick(1'b1);
    exp_rst = exp_rst + 16'h0001;
    wait_mode(pmc_pkg::PMC_NORMAL);
    st(pmc_pkg::PMC_NORMAL, 4'h3);
    chk("vector", 16'h0000, reset_vector);
    wr_reg(pmc_pkg::OFS_SUPV_CTRL, 8'h04);
    enter(8'h01);
    kick(1'b1);
    tick(5);
    st(pmc_pkg::PMC_IDLE, 4'hB);
    u_pmc_core_model.irq(1'b1);
    wait_mode(pmc_pkg::PMC_NORMAL);
    u_pmc_core_model.irq(1'b0);
    $display("test watchdog done");
    enter(8'h02);
    st(pmc_pkg::PMC_STOP, 4'h9);
    u_pmc_core_model.irq(1'b1);
    u_pmc_core_model.wake(2, 1'b1);
    tick(10);
    st(pmc_pkg::PMC_STOP, 4'h9);
    u_pmc_core_model.irq(1'b0);
    u_pmc_core_model.wake(2, 1'b0);
    kick(1'b0);
    exp_rst = exp_rst + 16'h0001;
    wait_mode(pmc_pkg::PMC_NORMAL);
    st(pmc_pkg::PMC_NORMAL, 4'h3);
    wr_reg(pmc_pkg::OFS_SUPV_CTRL, 8'h06);
    enter(8'h02);
    tick(10);
    st(pmc_pkg::PMC_STOP, 4'h9);
    exp_rst = exp_rst + 16'h0001;
    wait_mode(pmc_pkg::PMC_NORMAL);
    st(pmc_pkg::PMC_NORMAL, 4'h3);
    $display("test stop done");
    wr_reg(pmc_pkg::OFS_SUPV_CTRL, 8'h04);
    wr_reg(pmc_pkg::OFS_WAKE_CFG, 8'h20);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(pmc_pkg::OFS_WAKE_CFG, 8'h40 | (8'h01 << i));
      tick(2);
      st(pmc_pkg::PMC_SUSPEND, 4'hC);
      u_pmc_core_model.wake(i, 1'b1);
      wake_watch(1'b1);
      st(pmc_pkg::PMC_NORMAL, 4'h3);
      tick(3);
      chk_reg("flag", pmc_pkg::OFS_WAKE_CFG, 8'h01 << i);
      u_pmc_core_model.wake(i, 1'b0);
      wr_reg(pmc_pkg::OFS_WAKE_CFG, 8'h20);
      chk_reg("cleared", pmc_pkg::OFS_WAKE_CFG, 8'h00);
    end
    wr_reg(pmc_pkg::OFS_WAKE_CFG, 8'h40);
    tick(2);
    u_pmc_core_model.pin_glitch();
    wait_mode(pmc_pkg::PMC_NORMAL);
    st(pmc_pkg::PMC_NORMAL, 4'h3);
    tick(3);
    chk_reg("pin flag", pmc_pkg::OFS_WAKE_CFG, 8'h10);
    tick(3750);
    u_pmc_core_model.wake(1, 1'b1);
    tick(5);
    chk_reg("free flag", pmc_pkg::OFS_WAKE_CFG, 8'h12);
    wr_reg(pmc_pkg::OFS_WAKE_CFG, 8'h42);
    tick(3);
    st(pmc_pkg::PMC_NORMAL, 4'h3);
    u_pmc_core_model.wake(1, 1'b0);
    wr_reg(pmc_pkg::OFS_WAKE_CFG, 8'h20);
    $display("test suspend done");
    wr_reg(pmc_pkg::OFS_SUPV_CTRL, 8'h00);
    wr_reg(pmc_pkg::OFS_WAKE_CFG, 8'h81);
    tick(2);
    u_pmc_core_model.wake(0, 1'b1);
    tick(10);
    st(pmc_pkg::PMC_SLEEP, 4'hC);
    u_pmc_core_model.wake(0, 1'b0);
    u_pmc_core_model.pin_glitch();
    wait_mode(pmc_pkg::PMC_NORMAL);
    tick(3750);
    wr_reg(pmc_pkg::OFS_WAKE_CFG, 8'h20);
    wr_reg(pmc_pkg::OFS_SUPV_CTRL, 8'h04);
    wr_reg(pmc_pkg::OFS_WAKE_CFG, 8'hC1);
    tick(2);
    st(pmc_pkg::PMC_SLEEP, 4'hC);
    u_pmc_core_model.wake(0, 1'b1);
    wake_watch(1'b0);
    st(pmc_pkg::PMC_NORMAL, 4'h3);
    $display("test sleep done");
    end_sim();
  end
endmodule : power_mode_controller_tb
